// [design/mmic_pkg.sv]
// constants, field layout and carrier types of the multi-mode interval counter
package mmic_pkg;
   // ************************************************
   // sizes
   // ************************************************
   localparam int unsigned CH_N = 3;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 16;

   // ************************************************
   // register offsets (word index on the plain port)
   // ************************************************
   localparam logic [3:0] OFS_START = 4'h0;    // shared_start_register
   localparam logic [3:0] OFS_MODE0 = 4'h1;    // channel_mode_register 0..2 at 1..3
   localparam logic [3:0] OFS_COUNT0 = 4'h4;   // channel_count_register 0..2 at 4..6
   localparam logic [3:0] OFS_IRQ_STAT = 4'h7; // read-only sticky status
   localparam logic [3:0] OFS_IRQ_CLR = 4'h8;  // write-only, 1 clears
   localparam logic [3:0] OFS_IRQ_EN = 4'h9;

   // ************************************************
   // field positions
   // ************************************************
   localparam int unsigned RUN_LSB = 5;   // channel_run_bit 0..2 at bits 5..7
   localparam int unsigned MODE_LSB = 0;  // mode_select_low / mode_select_high
   localparam int unsigned EDGE_BIT = 2;  // 1 rising, 0 falling
   localparam int unsigned SEL_BIT = 3;   // event: 1 chained; measure: 1 width
   localparam int unsigned OVF_BIT = 5;   // overflow_flag, read only
   localparam int unsigned CKS_LSB = 6;   // clock select, 3 bits

   // ************************************************
   // reset values and divider counts
   // ************************************************
   localparam logic [15:0] RST_CNT = 16'h0000;
   localparam logic [15:0] CNT_MAX = 16'hffff;
   localparam logic [2:0] RST_CKS = 3'h0;
   localparam logic [2:0] RST_RUN = 3'h0;
   localparam logic [4:0] DIV_HALF_LAST = 5'h01;   // divide by 2
   localparam logic [4:0] DIV_EIGHTH_LAST = 5'h07; // divide by 8
   localparam logic [4:0] DIV_32_LAST = 5'h1f;     // divide by 32
   localparam logic [4:0] SUB_DIV_LAST = 5'h1f;    // sub-clock divide by 32

   // ************************************************
   // encodings
   // ************************************************
   typedef enum logic [1:0] {
      MMIC_MODE_TIMER = 2'h0,
      MMIC_MODE_EVENT = 2'h1,
      MMIC_MODE_MEAS = 2'h2,
      MMIC_MODE_NONE = 2'h3
   } mmic_mode_t;

   localparam logic [2:0] CKS_UNDIV = 3'h0;   // clk_undivided
   localparam logic [2:0] CKS_HALF = 3'h1;    // clk_half
   localparam logic [2:0] CKS_EIGHTH = 3'h2;  // clk_eighth
   localparam logic [2:0] CKS_32 = 3'h3;      // clk_thirtysecond
   localparam logic [2:0] CKS_SUB32 = 3'h4;   // subclock_div_thirtytwo

   typedef enum logic [2:0] {
      MMIC_ST_IDLE = 3'b001,   // stopped
      MMIC_ST_ARMED = 3'b010,  // started, no source pulse yet
      MMIC_ST_RUN = 3'b100     // counting
   } mmic_state_t;

   // ************************************************
   // carriers
   // ************************************************
   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } mmic_bus_t;

   typedef struct packed {
      logic sub32;
      logic div32;
      logic div8;
      logic div2;
      logic div1;
   } mmic_tick_t;
endpackage

// [design/mmic_prescaler.sv]
// count-source enables from the system clock and the sub-clock edges
`timescale 1ns/1ps
module mmic_prescaler (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // synchronised sub-clock rising edge
   input wire logic sub_edge_in,
   // enables
   output mmic_pkg::mmic_tick_t tick_out
);
   import mmic_pkg::*;

   logic [4:0] div_q;
   logic [4:0] sub_q;

   // free-running divider; enables other than div1, which stays high, are one cycle wide
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         div_q <= 5'h00;
      end else begin
         div_q <= div_q + 5'h01;
      end
   end

   // sub-clock edges divided by 32
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sub_q <= 5'h00;
      end else if (sub_edge_in) begin
         sub_q <= sub_q + 5'h01;
      end
   end

   // registered so the channels see clean pulses
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         tick_out <= '0;
      end else begin
         tick_out.div1 <= 1'b1;
         tick_out.div2 <= (div_q[0] == DIV_HALF_LAST[0]);
         tick_out.div8 <= (div_q[2:0] == DIV_EIGHTH_LAST[2:0]);
         tick_out.div32 <= (div_q == DIV_32_LAST);
         tick_out.sub32 <= sub_edge_in && (sub_q == SUB_DIV_LAST);
      end
   end
endmodule

// [design/mmic_sync.sv]
// three-stage pin synchroniser with edge pulses
`timescale 1ns/1ps
module mmic_sync #(
   parameter int unsigned W = 1
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // pins
   input wire logic [W-1:0] pin_in,
   // edges
   output logic [W-1:0] rise_out,
   output logic [W-1:0] fall_out
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // first stage feeds only the second
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // a change counts once stages two and three disagree
   assign rise_out = s2_q & ~s3_q;
   assign fall_out = ~s2_q & s3_q;
endmodule

// [design/mmic_top.sv]
// three-channel interval, event and pulse measurement counter
`timescale 1ns/1ps
module mmic_top (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // register port
   input mmic_pkg::mmic_bus_t bus_in,
   output logic [15:0] rd_data_out,
   // pins
   input wire logic [2:0] chan_input_pin_in,
   input wire logic subclk_pin_in,
   // interrupt
   output logic irq_out
);
   import mmic_pkg::*;

   // ************************************************
   // declarations
   // ************************************************
   mmic_tick_t tick;
   logic [2:0] pin_rise;
   logic [2:0] pin_fall;
   logic sub_rise;
   logic [2:0] run_q;
   mmic_mode_t md_q [CH_N];
   logic [2:0] edge_q;
   logic [2:0] sel_q;
   logic [2:0] cks_q [CH_N];
   logic [2:0] ovf_q;
   logic [2:0] aged_q;
   logic [2:0] first_q;
   logic [15:0] cnt_q [CH_N]; // 16-bit up/down counter per channel
   logic [15:0] rld_q [CH_N];
   mmic_state_t st_q [CH_N];
   logic [2:0] wrap_q;
   logic [2:0] stat_q;
   logic [2:0] en_q;
   logic [15:0] rd_data_q;
   logic irq_q;
   logic wr_start;
   logic wr_clr;
   logic wr_en;
   logic [2:0] wr_mode;
   logic [2:0] wr_cnt;
   logic [2:0] act;
   logic [2:0] dec;
   logic [2:0] meas;
   logic [2:0] src;
   logic [2:0] medge;
   logic [2:0] uf;
   logic [2:0] ovf;
   logic [2:0] evt;
   logic [2:0] run_new;

   assign rd_data_out = rd_data_q;
   assign irq_out = irq_q;

   // ************************************************
   // pin synchronisers and prescaler
   // ************************************************
   mmic_sync #(.W(3)) u_pin_sync (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .pin_in(chan_input_pin_in),
      .rise_out(pin_rise),
      .fall_out(pin_fall)
   );

   mmic_sync #(.W(1)) u_sub_sync (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .pin_in(subclk_pin_in),
      .rise_out(sub_rise),
      .fall_out()
   );

   mmic_prescaler u_presc (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .sub_edge_in(sub_rise),
      .tick_out(tick)
   );

   // ************************************************
   // address decode
   // ************************************************
   always_comb begin
      wr_start = 1'b0;
      wr_clr = 1'b0;
      wr_en = 1'b0;
      wr_mode = 3'h0;
      wr_cnt = 3'h0;
      if (!bus_in.wr) begin
         wr_start = 1'b0;
      end else if (bus_in.addr == OFS_START) begin
         wr_start = 1'b1;
      end else if (bus_in.addr >= OFS_MODE0 && bus_in.addr < OFS_COUNT0) begin
         wr_mode[2'(bus_in.addr - OFS_MODE0)] = 1'b1;
      end else if (bus_in.addr >= OFS_COUNT0 && bus_in.addr < OFS_IRQ_STAT) begin
         wr_cnt[2'(bus_in.addr - OFS_COUNT0)] = 1'b1;
      end else if (bus_in.addr == OFS_IRQ_CLR) begin
         wr_clr = 1'b1;
      end else if (bus_in.addr == OFS_IRQ_EN) begin
         wr_en = 1'b1;
      end
   end

   // ************************************************
   // per-channel count source and events
   // ************************************************
   always_comb begin
      run_new = bus_in.wdata[RUN_LSB +: 3];
      for (int i = 0; i < CH_N; i++) begin
         act[i] = (st_q[i] != MMIC_ST_IDLE);
         dec[i] = (md_q[i] == MMIC_MODE_TIMER) || (md_q[i] == MMIC_MODE_EVENT);
         meas[i] = (md_q[i] == MMIC_MODE_MEAS);
         // internal enable chosen by the clock select field
         case (cks_q[i])
            CKS_UNDIV: src[i] = tick.div1;
            CKS_HALF: src[i] = tick.div2;
            CKS_EIGHTH: src[i] = tick.div8;
            CKS_32: src[i] = tick.div32;
            CKS_SUB32: src[i] = tick.sub32;
            default: src[i] = 1'b0;
         endcase
         if (md_q[i] == MMIC_MODE_EVENT) begin
            // chained wrap from the previous channel, 0 takes 2
            if (sel_q[i]) begin
               src[i] = wrap_q[(i + CH_N - 1) % CH_N];
            end else begin
               src[i] = edge_q[i] ? pin_rise[i] : pin_fall[i];
            end
         end
         if (md_q[i] == MMIC_MODE_NONE) begin
            src[i] = 1'b0;
         end
         // width takes every edge, period one polarity
         if (sel_q[i]) begin
            medge[i] = meas[i] && act[i] && (pin_rise[i] || pin_fall[i]);
         end else begin
            medge[i] = meas[i] && act[i] && (edge_q[i] ? pin_rise[i] : pin_fall[i]);
         end
         uf[i] = dec[i] && act[i] && src[i] && (cnt_q[i] == RST_CNT);
         // an edge clearing the counter hides a wrap in the same cycle
         ovf[i] = meas[i] && act[i] && src[i] && !medge[i] && (cnt_q[i] == CNT_MAX);
         evt[i] = uf[i] || ovf[i] || (medge[i] && first_q[i]);
      end
   end

   // ************************************************
   // run control and channel state
   // ************************************************
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         run_q <= RST_RUN;
         for (int i = 0; i < CH_N; i++) begin
            st_q[i] <= MMIC_ST_IDLE;
         end
      end else begin
         if (wr_start) begin
            run_q <= run_new;
         end
         for (int i = 0; i < CH_N; i++) begin
            if (wr_start && !run_new[i]) begin
               st_q[i] <= MMIC_ST_IDLE;
            end else if (wr_start && !run_q[i]) begin
               st_q[i] <= MMIC_ST_ARMED;
            end else begin
               case (st_q[i])
                  MMIC_ST_ARMED: begin
                     if (src[i]) begin
                        st_q[i] <= MMIC_ST_RUN;
                     end
                  end
                  MMIC_ST_RUN: st_q[i] <= MMIC_ST_RUN;
                  default: st_q[i] <= MMIC_ST_IDLE;
               endcase
            end
         end
      end
   end

   // ************************************************
   // mode registers and overflow flag
   // ************************************************
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         edge_q <= 3'h0;
         sel_q <= 3'h0;
         ovf_q <= 3'h0;
         aged_q <= 3'h0;
         for (int i = 0; i < CH_N; i++) begin
            md_q[i] <= MMIC_MODE_TIMER;
            cks_q[i] <= RST_CKS;
         end
      end else begin
         for (int i = 0; i < CH_N; i++) begin
            if (wr_mode[i]) begin
               md_q[i] <= mmic_mode_t'(bus_in.wdata[MODE_LSB +: 2]);
               edge_q[i] <= bus_in.wdata[EDGE_BIT];
               sel_q[i] <= bus_in.wdata[SEL_BIT];
               cks_q[i] <= bus_in.wdata[CKS_LSB +: 3];
            end
            // set beats clear; clear needs a tick after the set
            if (ovf[i]) begin
               ovf_q[i] <= 1'b1;
               aged_q[i] <= 1'b0;
            end else if (wr_mode[i] && run_q[i] && aged_q[i]) begin
               ovf_q[i] <= 1'b0;
               aged_q[i] <= 1'b0;
            end else if (ovf_q[i] && src[i] && act[i]) begin
               aged_q[i] <= 1'b1;
            end
         end
      end
   end

   // ************************************************
   // counter and reload register
   // ************************************************
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         first_q <= 3'h0;
         for (int i = 0; i < CH_N; i++) begin
            cnt_q[i] <= RST_CNT;
            rld_q[i] <= RST_CNT;
         end
      end else begin
         for (int i = 0; i < CH_N; i++) begin
            if (meas[i]) begin
               // count writes never touch a measuring channel
               if (wr_start && run_new[i] && !run_q[i]) begin
                  first_q[i] <= 1'b0;
               end else if (medge[i]) begin
                  rld_q[i] <= cnt_q[i];
                  cnt_q[i] <= RST_CNT;
                  first_q[i] <= 1'b1;
               end else if (act[i] && src[i]) begin
                  cnt_q[i] <= cnt_q[i] + 16'h0001;
               end
            end else if (dec[i]) begin
               if (wr_cnt[i]) begin
                  rld_q[i] <= bus_in.wdata;
               end
               // while stopped or before the first source pulse a write also loads the counter
               if (wr_cnt[i] && st_q[i] != MMIC_ST_RUN) begin
                  cnt_q[i] <= bus_in.wdata;
               end else if (uf[i]) begin
                  cnt_q[i] <= rld_q[i];
               end else if (act[i] && src[i]) begin
                  cnt_q[i] <= cnt_q[i] - 16'h0001;
               end
            end
         end
      end
   end

   // wrap pulses feed the next channel's event input
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         wrap_q <= 3'h0;
      end else begin
         wrap_q <= uf | ovf;
      end
   end

   // ************************************************
   // interrupts
   // ************************************************
   // an event in the clear cycle survives
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         stat_q <= 3'h0;
         en_q <= 3'h0;
         irq_q <= 1'b0;
      end else begin
         stat_q <= (stat_q & ~(wr_clr ? bus_in.wdata[2:0] : 3'h0)) | evt;
         if (wr_en) begin
            en_q <= bus_in.wdata[2:0];
         end
         irq_q <= |(stat_q & en_q);
      end
   end

   // ************************************************
   // read data, one cycle after the strobe
   // ************************************************
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rd_data_q <= 16'h0000;
      end else if (!bus_in.rd) begin
         rd_data_q <= 16'h0000;
      end else if (bus_in.addr == OFS_START) begin
         rd_data_q <= {8'h00, run_q, 5'h00};
      end else if (bus_in.addr >= OFS_MODE0 && bus_in.addr < OFS_COUNT0) begin
         rd_data_q <= 16'h0000;
         for (int i = 0; i < CH_N; i++) begin
            if (bus_in.addr == OFS_MODE0 + 4'(i)) begin
               rd_data_q <= {7'h00, cks_q[i], ovf_q[i], 1'b0,
                             sel_q[i], edge_q[i], md_q[i]};
            end
         end
      end else if (bus_in.addr >= OFS_COUNT0 && bus_in.addr < OFS_IRQ_STAT) begin
         rd_data_q <= 16'h0000;
         for (int i = 0; i < CH_N; i++) begin
            if (bus_in.addr == OFS_COUNT0 + 4'(i)) begin
               rd_data_q <= meas[i] ? rld_q[i] : cnt_q[i];
            end
         end
      end else if (bus_in.addr == OFS_IRQ_STAT) begin
         rd_data_q <= {13'h0000, stat_q};
      end else if (bus_in.addr == OFS_IRQ_EN) begin
         rd_data_q <= {13'h0000, en_q};
      end else begin
         rd_data_q <= 16'h0000;
      end
   end

   // ************************************************
   // assertions on the run bits and channel 0
   // ************************************************
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);

   sequence s_start0;
      wr_start && run_new[0] && !run_q[0];
   endsequence
   sequence s_first_src0;
      st_q[0] == MMIC_ST_ARMED && src[0] && !wr_start;
   endsequence

   property p_run_bits;
      wr_start |=> run_q == $past(bus_in.wdata[7:5]);
   endproperty
   a_run_bits: assert property (p_run_bits) else $error("run bits wrong");

   property p_start_seq;
      s_start0 ##1 s_first_src0 |=> st_q[0] == MMIC_ST_RUN;
   endproperty
   a_start_seq: assert property (p_start_seq) else $error("start sequence");

   property p_underflow;
      uf[0] && !wr_cnt[0] |=> cnt_q[0] == $past(rld_q[0]) && stat_q[0];
   endproperty
   a_underflow: assert property (p_underflow) else $error("no reload");

   property p_decrement;
      dec[0] && act[0] && src[0] && cnt_q[0] != 16'h0000 && !wr_cnt[0]
         |=> cnt_q[0] == $past(cnt_q[0]) - 16'h0001;
   endproperty
   a_decrement: assert property (p_decrement) else $error("bad decrement");

   property p_load_both;
      dec[0] && wr_cnt[0] && st_q[0] != MMIC_ST_RUN
         |=> cnt_q[0] == $past(bus_in.wdata) && rld_q[0] == $past(bus_in.wdata);
   endproperty
   a_load_both: assert property (p_load_both) else $error("load both");

   property p_load_reload;
      dec[0] && wr_cnt[0] && st_q[0] == MMIC_ST_RUN && !src[0]
         |=> cnt_q[0] == $past(cnt_q[0]) && rld_q[0] == $past(bus_in.wdata);
   endproperty
   a_load_reload: assert property (p_load_reload) else $error("reload only");

   property p_capture;
      medge[0] |=> cnt_q[0] == 16'h0000 && rld_q[0] == $past(cnt_q[0]);
   endproperty
   a_capture: assert property (p_capture) else $error("bad capture");

   property p_first_quiet;
      medge[0] && !first_q[0] && !stat_q[0] |=> !stat_q[0];
   endproperty
   a_first_quiet: assert property (p_first_quiet) else $error("first edge irq");

   property p_ovf_flag;
      ovf[0] |=> ovf_q[0] && stat_q[0];
   endproperty
   a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag");

   property p_ovf_hold;
      ovf_q[0] && !aged_q[0] && wr_mode[0] |=> ovf_q[0];
   endproperty
   a_ovf_hold: assert property (p_ovf_hold) else $error("early clear");

   property p_meas_read;
      meas[0] && bus_in.rd && bus_in.addr == OFS_COUNT0 |=> rd_data_q == $past(rld_q[0]);
   endproperty
   a_meas_read: assert property (p_meas_read) else $error("measure read");

   property p_meas_nowrite;
      meas[0] && wr_cnt[0] && !medge[0] |=> rld_q[0] == $past(rld_q[0]);
   endproperty
   a_meas_nowrite: assert property (p_meas_nowrite) else $error("write leaked");
endmodule

// [tb/mmic_pulse_src.sv]
// partner model: periodic pulse source on a channel input pin
`timescale 1ns/1ps
module mmic_pulse_src #(
   parameter int unsigned H = 20
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // control and pin
   input wire logic go_in,
   output logic pin_out
);
   logic [7:0] cnt_q;
   // square wave of half period h; low while idle, so the first edge is a rise
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_q <= 8'h00;
         pin_out <= 1'b0;
      end else if (!go_in) begin
         cnt_q <= 8'h00;
         pin_out <= 1'b0;
      end else if (cnt_q == 8'(H - 1)) begin
         cnt_q <= 8'h00;
         pin_out <= ~pin_out; // equal levels, so width is half the period
      end else begin
         cnt_q <= cnt_q + 8'h01;
      end
   end
endmodule

// [tb/tb_top.sv]
// self-checking bench of the multi-mode interval counter
`timescale 1ns/1ps
module tb_top;
   import mmic_pkg::*;
   localparam int H = 20;
   logic sys_clk_in;
   logic rst_in;
   logic subclk_pin_in;
   logic irq_out;
   logic go;
   logic p0;
   logic [2:1] pins;
   logic [15:0] rd_data_out;
   mmic_bus_t bus;
   int n_errors = 0;
   int n_tests = 0;
   int cyc = 0;

   mmic_top u_mmic_top (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus_in(bus),
      .rd_data_out(rd_data_out), .chan_input_pin_in({pins, p0}),
      .subclk_pin_in(subclk_pin_in), .irq_out(irq_out));
   mmic_pulse_src #(.H(H)) u_mmic_pulse_src (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .go_in(go), .pin_out(p0));

   initial begin
      sys_clk_in = 1'b0;
      forever #20 sys_clk_in = ~sys_clk_in;
   end
   // sub-clock of four system periods, moved on the rising edge like every input
   initial begin
      subclk_pin_in = 1'b0;
      forever begin
         repeat (2) @(posedge sys_clk_in);
         subclk_pin_in <= ~subclk_pin_in;
      end
   end
   always @(posedge sys_clk_in) cyc <= cyc + 1;

   task test_done();
      if (n_errors == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
         n_errors++;
      end
   endtask

   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk_in);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge sys_clk_in);
      bus.wr <= 1'b0;
   endtask

   // data stand only in the cycle after the strobe
   task rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge sys_clk_in);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge sys_clk_in);
      bus.rd <= 1'b0;
      #1;
      v = rd_data_out;
   endtask

   task wait_irq(input logic lvl, input int lim);
      int i;
      i = 0;
      while (irq_out !== lvl && i < lim) begin
         @(posedge sys_clk_in);
         #1;
         i++;
      end
      if (irq_out !== lvl) begin
         n_errors++;
         test_done();
      end
   endtask

   // clear the sticky bits, then stamp the next request
   task nxt_irq(output int t);
      wr(OFS_IRQ_CLR, 16'h0007);
      wait_irq(1'b0, 40);
      wait_irq(1'b1, 4000);
      t = cyc;
   endtask

   // ************************************************
   // scenarios
   // ************************************************
   task t_reset();
      logic [15:0] v;
      rd(OFS_START, v);
      chk(v, 16'h0000);
      rd(4'hf, v);
      chk(v, 16'h0000);
      rd(OFS_IRQ_STAT, v);
      chk(v, 16'h0000);
      chk({15'h0, irq_out}, 16'h0000);
   endtask

   task t_timer();
      int dv [5] = '{1, 2, 8, 32, 128};
      int t0;
      int t1;
      for (int k = 0; k < 5; k++) begin
         wr(OFS_MODE0, {7'h00, 3'(k), 6'h00});
         wr(OFS_COUNT0, 16'h000f);
         wr(OFS_IRQ_EN, 16'h0001);
         wr(OFS_START, 16'h0020);
         nxt_irq(t0);
         nxt_irq(t1);
         chk(16'(t1 - t0), 16'(16 * dv[k]));
         // written while channel 0 is running, so only the reload takes it
         if (k == 2) begin
            wr(OFS_COUNT0, 16'h001f);
            nxt_irq(t0);
            nxt_irq(t1);
            chk(16'(t1 - t0), 16'(32 * dv[k]));
         end
         wr(OFS_START, 16'h0000);
      end
   endtask

   task pin1(input logic lvl, output logic [15:0] v);
      @(posedge sys_clk_in);
      pins[1] <= lvl;
      repeat (8) @(posedge sys_clk_in);
      rd(OFS_COUNT0 + 4'h1, v);
   endtask

   // channel 1 counts falling pin edges only
   task t_event();
      logic [15:0] v;
      wr(OFS_MODE0 + 4'h1, 16'h0001);
      wr(OFS_COUNT0 + 4'h1, 16'h0005);
      wr(OFS_START, 16'h0040);
      pin1(1'b1, v);
      chk(v, 16'h0005);
      pin1(1'b0, v);
      chk(v, 16'h0004);
      wr(OFS_START, 16'h0000);
      pin1(1'b1, v);
      pin1(1'b0, v);
      chk(v, 16'h0004);
   endtask

   // channel 2 wraps every 4 cycles; channel 0 counts ten of them
   task t_chain();
      logic [15:0] v;
      int t0;
      int t1;
      wr(OFS_MODE0 + 4'h2, 16'h0000);
      wr(OFS_COUNT0 + 4'h2, 16'h0003);
      wr(OFS_MODE0, 16'h0009);
      wr(OFS_COUNT0, 16'h0009);
      wr(OFS_START, 16'h00a0);
      nxt_irq(t0);
      nxt_irq(t1);
      chk(16'(t1 - t0), 16'h0028);
      rd(OFS_IRQ_EN, v);
      chk(v, 16'h0001);
      wr(OFS_START, 16'h0000);
   endtask

   task meas(input logic sel, output logic [15:0] cap);
      logic [15:0] v;
      int t0;
      int e;
      e = sel ? 2 * H : 3 * H;
      wr(OFS_MODE0, {12'h000, sel, 3'h6});
      wr(OFS_IRQ_CLR, 16'h0007);
      wr(OFS_START, 16'h0020);
      go <= 1'b1;
      t0 = cyc;
      wait_irq(1'b1, 200);
      chk({15'h0, (cyc - t0 >= e) && (cyc - t0 <= e + 8)}, 16'h0001);
      rd(OFS_COUNT0, cap);
      wr(OFS_COUNT0, 16'h0000);
      nxt_irq(t0);
      rd(OFS_COUNT0, v);
      chk(v, cap);
      wr(OFS_START, 16'h0000);
      go <= 1'b0;
   endtask

   task t_meas();
      logic [15:0] p;
      logic [15:0] w;
      meas(1'b0, p);
      meas(1'b1, w);
      chk(p - w, 16'(H));
   endtask

   // counter preloaded near the top in timer mode, then measured on /32 with no pin edges
   task t_ovf();
      logic [15:0] v;
      wr(OFS_MODE0, 16'h0000);
      wr(OFS_COUNT0, 16'hfff0);
      wr(OFS_MODE0, 16'h00c2);
      wr(OFS_IRQ_CLR, 16'h0007);
      wr(OFS_START, 16'h0020);
      wait_irq(1'b1, 1000);
      // before the next /32 tick a mode write must not clear the flag
      wr(OFS_MODE0, 16'h00c2);
      rd(OFS_MODE0, v);
      chk(v, 16'h00e2);
      repeat (40) @(posedge sys_clk_in);
      wr(OFS_START, 16'h0000);
      wr(OFS_MODE0, 16'h00c2);
      rd(OFS_MODE0, v);
      chk(v, 16'h00e2);
      wr(OFS_START, 16'h0020);
      wr(OFS_MODE0, 16'h00c2);
      rd(OFS_MODE0, v);
      chk(v, 16'h00c2);
   endtask

   initial begin
      rst_in = 1'b1;
      bus = '0;
      pins = '0;
      go = 1'b0;
      repeat (3) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      t_reset();
      t_timer();
      t_event();
      t_chain();
      t_meas();
      t_ovf();
      test_done();
   end
endmodule
